// File: core/sync_consts.svh
// Offsets, field positions, reset values and timing figures of the sync block
`ifndef SYNC_CONSTS_SVH
`define SYNC_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define US_NS 1000
`define CSI_UNIT_NS 10000000

`define OFS_MODE 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_TS_STATUS 8'h0C
`define OFS_TS_COMMAND 8'h10
`define OFS_RX_DELAY 8'h14
`define OFS_CSI 8'h18
`define OFS_TS_BASE 8'h1C

`define IRQ_NUM 4
`define IRQ_DX 0
`define IRQ_TS 1
`define IRQ_OVF 2
`define IRQ_VIOL 3
`define IRQ_MASK_RST 4'hF

`define MODE_W 4
`define MODE_RST 4'h0
`define TS_SET_TIME 0
`define TS_VIOLATION 1
`define CMD_STOP 0
`define CMD_IGNORE_CYC 1
`define CSI_W 16
`define TS_BASE_2K 12'h7E0
`define TS_BASE_4K 12'hFE0

`endif

// File: core/sync_pkg.sv
// Types shared by the sync and clock-sync logic
package sync_pkg;

    typedef struct packed {
        logic mem_4k;
        logic sync_pol;
        logic isochron_mode;
        logic sync_via_output_irq_enable;
    } mode_t;

    typedef struct packed {
        logic dx_telegram;
        logic sync_bcast;
        logic time_event;
        logic clock_value;
        logic leave_or_prm;
    } rx_event_t;

    typedef enum logic [1:0] {
        TR_STOPPED,
        TR_ARMED,
        TR_MEASURE,
        TR_HELD
    } tr_state_t;

endpackage

// File: core/event_flags.sv
// Sticky event flags with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "sync_consts.svh"
module event_flags #(
    parameter int N = `IRQ_NUM
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Events and software access
    input wire logic [N-1:0] set,
    input wire logic clr_we,
    input wire logic [N-1:0] clr_data,
    input wire logic mask_we,
    input wire logic [N-1:0] mask_data,
    // State
    output logic [N-1:0] status_q,
    output logic [N-1:0] mask_q,
    output logic irq_q
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= `IRQ_MASK_RST;
        end else if (mask_we) begin
            mask_q <= mask_data;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            // Set wins over a clear in the same cycle
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    status_q[i] <= 1'b0;
                end else if (set[i]) begin
                    status_q[i] <= 1'b1;
                end else if (clr_we && clr_data[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & ~mask_q);
        end
    end
endmodule
`default_nettype wire

// File: core/rx_delay_timer.sv
// Microsecond receive delay timer with start, stop and halt on overflow
`timescale 1ns/1ps
`default_nettype none
`include "sync_consts.svh"
module rx_delay_timer #(
    parameter int W = 32,
    parameter int PRESCALE = `US_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    input wire logic stop,
    // State
    output logic [W-1:0] count_q,
    output logic running_q,
    output logic overflow_q
);
    localparam int PW = $clog2(PRESCALE);
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
    logic [PW-1:0] pre_q;
    logic tick;

    assign tick = running_q && (pre_q == PRE_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
        end else if (start || tick) begin
            pre_q <= '0;
        end else if (running_q) begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // A restart zeroes the count; a stop freezes it for reading
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (start) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= count_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_q <= 1'b0;
        end else if (start) begin
            running_q <= 1'b1;
        end else if (stop || (tick && &count_q)) begin
            running_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_q <= 1'b0;
        end else begin
            overflow_q <= tick && &count_q && !start;
        end
    end
endmodule
`default_nettype wire

// File: core/simple_sync_clock_sync.sv
// Simple sync mode and clock-sync receiver with APB register access
//
// Operation
// - Sync output uses the same polarity setting as isochron mode.
// - Output-data interrupt held until a later sync broadcast arrives.
// - Sync broadcast without prior exchange telegram gives no sync signal.
// - Sync signal passes the interrupt mask; masked means no signal.
// - Sync signal stays asserted until host acknowledges the interrupt.
// - Timing-marker broadcast starts the receive delay timer.
// - Time-value broadcast raises the time-sync interrupt.
// - Timer keeps counting until host reads the receive delay value or the timer overflows.
// - No new sync data while the time-sync interrupt is pending.
// - Timer overflow clears the time-sync buffer status byte.
// - Buffer base is 7E0 in 2K mode, FE0 in 4K mode.
`timescale 1ns/1ps
`default_nettype none
`include "sync_consts.svh"
module simple_sync_clock_sync
    import sync_pkg::*;
#(
    parameter int CSI_UNIT_CYCLES = `CSI_UNIT_NS / `CLK_PERIOD_NS,
    parameter int TIMER_W = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received telegram events, one-cycle pulses
    input wire rx_event_t rx_event,
    // Outputs
    output logic sync_out,
    output logic irq
);
    localparam int UW = $clog2(CSI_UNIT_CYCLES + 1);
    localparam logic [UW-1:0] UNIT_LAST = UW'(CSI_UNIT_CYCLES - 1);

    mode_t mode_q;
    tr_state_t tr_q;
    logic [1:0] ts_status_q;
    logic ignore_cyc_q;
    logic [`CSI_W-1:0] csi_q;
    logic dx_pending_q;
    logic [UW-1:0] unit_q;
    logic [`CSI_W:0] wd_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic sync_q;

    logic setup;
    logic wr;
    logic rd;
    logic simple_mode;
    logic [`IRQ_NUM-1:0] irq_set;
    logic [`IRQ_NUM-1:0] irq_status;
    logic [`IRQ_NUM-1:0] irq_mask;
    logic irq_q;
    logic ts_pending;
    logic timer_start;
    logic timer_stop;
    logic [TIMER_W-1:0] timer_count;
    logic timer_running;
    logic timer_ovf;
    logic unit_tick;
    logic wd_expired;
    logic stop_cmd;
    logic csi_wr;
    logic marker_taken;
    logic value_taken;
    logic [31:0] rd_mux;
    logic addr_ok;

    assign setup = psel && !penable;
    assign wr = psel && penable && pready_q && pwrite;
    assign rd = psel && penable && pready_q && !pwrite;

    // host selects the mode through these two bits
    assign simple_mode = mode_q.sync_via_output_irq_enable
        && !mode_q.isochron_mode;

    always_comb begin
        addr_ok = 1'b1;
        rd_mux = '0;
        case (paddr)
            `OFS_MODE: rd_mux = 32'(mode_q);
            `OFS_IRQ_STATUS: rd_mux = 32'(irq_status);
            `OFS_IRQ_MASK: rd_mux = 32'(irq_mask);
            `OFS_TS_STATUS: rd_mux = 32'(ts_status_q);
            `OFS_TS_COMMAND: rd_mux = 32'({ignore_cyc_q, 1'b0});
            `OFS_RX_DELAY: rd_mux = 32'(timer_count);
            `OFS_CSI: rd_mux = 32'(csi_q);
            `OFS_TS_BASE: rd_mux = mode_q.mem_4k ? 32'(`TS_BASE_4K)
                                                 : 32'(`TS_BASE_2K);
            default: addr_ok = 1'b0;
        endcase
    end

    // Zero-wait answer: ready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !addr_ok;
            if (setup && !pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= mode_t'(`MODE_RST);
        end else if (wr && paddr == `OFS_MODE) begin
            mode_q <= mode_t'(pwdata[`MODE_W-1:0]);
        end
    end

    assign csi_wr = wr && paddr == `OFS_CSI;
    assign stop_cmd = wr && paddr == `OFS_TS_COMMAND
        && pwdata[`CMD_STOP];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ignore_cyc_q <= 1'b0;
        end else if (wr && paddr == `OFS_TS_COMMAND) begin
            ignore_cyc_q <= pwdata[`CMD_IGNORE_CYC];
        end
    end

    // Interval is locked while the time receiver runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csi_q <= '0;
        end else if (csi_wr && tr_q == TR_STOPPED) begin
            csi_q <= pwdata[`CSI_W-1:0];
        end
    end

    // exchange telegram stored, not reported, in simple mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dx_pending_q <= 1'b0;
        end else if (!simple_mode) begin
            dx_pending_q <= 1'b0;
        // sync broadcast consumes the stored exchange
        // Same-cycle exchange is consumed too, or it would fire twice
        end else if (rx_event.sync_bcast) begin
            dx_pending_q <= 1'b0;
        end else if (rx_event.dx_telegram) begin
            dx_pending_q <= 1'b1;
        end
    end

    always_comb begin
        irq_set = '0;
        // delayed interrupt on sync; nothing without exchange
        if (simple_mode) begin
            irq_set[`IRQ_DX] = rx_event.sync_bcast
                && (dx_pending_q || rx_event.dx_telegram);
        end else begin
            irq_set[`IRQ_DX] = rx_event.dx_telegram;
        end
        // time value raises the time-sync interrupt
        irq_set[`IRQ_TS] = value_taken;
        irq_set[`IRQ_OVF] = timer_ovf;
        irq_set[`IRQ_VIOL] = wd_expired;
    end

    event_flags #(
        .N(`IRQ_NUM)
    ) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set(irq_set),
        .clr_we(wr && paddr == `OFS_IRQ_STATUS),
        .clr_data(pwdata[`IRQ_NUM-1:0]),
        .mask_we(wr && paddr == `OFS_IRQ_MASK),
        .mask_data(pwdata[`IRQ_NUM-1:0]),
        .status_q(irq_status),
        .mask_q(irq_mask),
        .irq_q(irq_q)
    );

    // masked interrupt gives no sync; level until acknowledge
    // polarity bit shared with isochron mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= mode_q.sync_pol ^ (simple_mode
                && irq_status[`IRQ_DX] && !irq_mask[`IRQ_DX]);
        end
    end

    // held buffer refuses new sync data
    assign ts_pending = irq_status[`IRQ_TS];
    assign marker_taken = rx_event.time_event && !ts_pending
        && (tr_q == TR_ARMED || tr_q == TR_MEASURE);
    assign value_taken = rx_event.clock_value && !ts_pending
        && tr_q == TR_MEASURE && !marker_taken;

    // Time receiver; started by the interval write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tr_q <= TR_STOPPED;
        end else if (stop_cmd
                     || (rx_event.leave_or_prm && !ignore_cyc_q)) begin
            tr_q <= TR_STOPPED;
        end else begin
            case (tr_q)
                TR_STOPPED: begin
                    if (csi_wr) begin
                        tr_q <= TR_ARMED;
                    end
                end
                TR_ARMED: begin
                    if (marker_taken) begin
                        tr_q <= TR_MEASURE;
                    end
                end
                TR_MEASURE: begin
                    if (value_taken) begin
                        tr_q <= TR_HELD;
                    end else if (wd_expired) begin
                        tr_q <= TR_ARMED;
                    end
                end
                TR_HELD: begin
                    if (!ts_pending) begin
                        tr_q <= TR_ARMED;
                    end
                end
                default: tr_q <= TR_STOPPED;
            endcase
        end
    end

    assign timer_start = marker_taken;
    // a read of the delay value stops it; an overflow stops it too
    assign timer_stop = rd && paddr == `OFS_RX_DELAY;

    rx_delay_timer #(
        .W(TIMER_W)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(timer_start),
        .stop(timer_stop),
        .count_q(timer_count),
        .running_q(timer_running),
        .overflow_q(timer_ovf)
    );

    // Guard of twice the interval from marker to time value
    assign unit_tick = tr_q == TR_MEASURE && unit_q == UNIT_LAST;
    assign wd_expired = unit_tick && wd_q >= {csi_q, 1'b0}
        && !value_taken && !marker_taken;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_q <= '0;
        end else if (marker_taken || unit_tick || tr_q != TR_MEASURE) begin
            unit_q <= '0;
        end else begin
            unit_q <= unit_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_q <= '0;
        end else if (marker_taken || tr_q != TR_MEASURE) begin
            wd_q <= '0;
        end else if (unit_tick && !(&wd_q)) begin
            wd_q <= wd_q + 1'b1;
        end
    end

    // Buffer status byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ts_status_q <= '0;
        end else if (timer_ovf) begin
            ts_status_q <= '0;
        end else if (value_taken) begin
            ts_status_q[`TS_SET_TIME] <= 1'b1;
            ts_status_q[`TS_VIOLATION] <= 1'b0;
        end else if (wd_expired) begin
            ts_status_q[`TS_VIOLATION] <= 1'b1;
        end else if (marker_taken) begin
            ts_status_q[`TS_SET_TIME] <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign sync_out = sync_q;
    assign irq = irq_q;
endmodule
`default_nettype wire

// File: test/sync_checker.sv
// Checker for APB answers, sync output and interrupt of the sync block
`timescale 1ns/1ps
`default_nettype none
module sync_checker
    import sync_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Telegrams and outputs
    input wire rx_event_t rx_event,
    input wire logic sync_out,
    input wire logic irq
);
    logic wr_done;
    logic mapped;
    assign wr_done = psel && penable && pready && pwrite;
    assign mapped = paddr <= 8'h1C && paddr[1:0] == 2'h0;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    // Quiet clearing cycle, since a new event wins over the clear
    sequence clear_quiet_s;
        wr_done && paddr == 8'h04 && pwdata[3:0] == 4'hF && rx_event == '0
        ##1 rx_event == '0;
    endsequence
    sequence mask_all_s;
        wr_done && paddr == 8'h08 && pwdata[3:0] == 4'hF;
    endsequence
    a_ready_after_setup: assert property (setup_s |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (setup_s ##0 !mapped |=> pslverr)
        else $error("no error on unmapped address");
    a_mapped_ok: assert property (setup_s ##0 mapped |=> !pslverr)
        else $error("error on mapped address");
    a_err_reads_zero: assert property (
        pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_base_value: assert property (
        pready && !pwrite && paddr == 8'h1C
        |-> prdata == 32'h7E0 || prdata == 32'hFE0)
        else $error("buffer base value wrong");
    a_sync_has_cause: assert property (
        $changed(sync_out)
        |-> $past(rx_event.sync_bcast, 2) || $past(wr_done, 2))
        else $error("sync output moved without cause");
    a_mask_quiets_irq: assert property (mask_all_s |=> ##1 !irq)
        else $error("irq high with all masked");
    a_clear_drops_irq: assert property (clear_quiet_s |=> !irq)
        else $error("irq stays after clear");
endmodule

bind simple_sync_clock_sync sync_checker chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_event(rx_event), .sync_out(sync_out),
    .irq(irq));
`default_nettype wire

// File: test/bus_master_model.sv
// Far-side telegram source: exchange, sync and clock-sync broadcasts
`timescale 1ns/1ps
`default_nettype none
module bus_master_model
    import sync_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Decoded telegram pulses
    output var rx_event_t rx_event
);
    initial rx_event = '0;
    task automatic send(input rx_event_t ev);
        @(posedge pclk);
        rx_event <= ev;
        @(posedge pclk);
        rx_event <= '0;
    endtask
    // user parameters from byte 10 stay above this port
    // interval reaches the block as a host register write
    // marker then value
    // Value payload itself stays above this port
    task automatic clock_sync(input int gap);
        send(5'h04);
        repeat (gap) @(posedge pclk);
        send(5'h02);
    endtask
endmodule
`default_nettype wire

// File: test/simple_sync_clock_sync_tb.sv
// Self-checking bench for simple sync and clock-sync
`timescale 1ns/1ps
`default_nettype none
module simple_sync_clock_sync_tb;
    import sync_pkg::*;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rx_event_t rx_event;
    logic sync_out;
    logic irq;
    logic [31:0] lfsr_q;
    logic [31:0] rd;
    logic [31:0] t0;
    logic err;
    int n_mismatch;
    int checks_done;
    int gap;
    int ex;

    simple_sync_clock_sync #(.CSI_UNIT_CYCLES(20), .TIMER_W(32)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_event(rx_event),
        .sync_out(sync_out), .irq(irq));
    bus_master_model master (.pclk(pclk), .rx_event(rx_event));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic exp_sync(input logic pol, pend, msk);
        return pol ^ (pend & ~msk);
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("Counts: %0d checks, %0d mismatches", checks_done,
            n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Holds the request until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : lfsr_q;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task settle;
        repeat (2) @(posedge pclk);
        lfsr_q = lfsr_next(lfsr_q);
    endtask

    initial begin
        #400000;
        n_mismatch++;
        close_out;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lfsr_q = 32'h5706CB3D;
        n_mismatch = 0;
        checks_done = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        check(rd, 32'hF);
        apb(1'b0, 8'h1C, 32'h0);
        check(rd, 32'h7E0);
        apb(1'b1, 8'h00, 32'h8);
        apb(1'b0, 8'h1C, 32'h0);
        check(rd, 32'hFE0);
        apb(1'b0, 8'h20, 32'h0);
        check({rd[30:0], err}, 32'h1);
        $display("Done: reset values and map");
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 2; m++) begin
                apb(1'b1, 8'h00, {29'h0, p[0], 2'h1});
                apb(1'b1, 8'h08, {28'h0, 3'h7, m[0]});
                apb(1'b1, 8'h04, 32'hF);
                master.send(5'h08);
                settle;
                check(32'(sync_out), 32'(exp_sync(p[0], 0, m[0])));
                repeat (lfsr_q[1:0] + 1) master.send(5'h10);
                settle;
                check(32'(sync_out), 32'(exp_sync(p[0], 0, m[0])));
                master.send(5'h08);
                settle;
                check(32'(sync_out), 32'(exp_sync(p[0], 1, m[0])));
                check(32'(irq), 32'(!m[0]));
                repeat (lfsr_q[5:0]) @(posedge pclk);
                check(32'(sync_out), 32'(exp_sync(p[0], 1, m[0])));
                apb(1'b1, 8'h04, 32'h1);
                settle;
                check(32'(sync_out), 32'(exp_sync(p[0], 0, m[0])));
                master.send(5'h08);
                settle;
                check(32'(sync_out), 32'(exp_sync(p[0], 0, m[0])));
                // Exchange and sync in one cycle count once
                master.send(5'h18);
                settle;
                check(32'(sync_out), 32'(exp_sync(p[0], 1, m[0])));
                apb(1'b1, 8'h04, 32'h1);
                master.send(5'h08);
                settle;
                check(32'(sync_out), 32'(exp_sync(p[0], 0, m[0])));
            end
        end
        $display("Done: simple sync");
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h08, 32'hD);
        apb(1'b1, 8'h18, 32'h64);
        gap = 300 + lfsr_q[8:0];
        master.clock_sync(gap);
        settle;
        check(32'(irq), 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h1);
        repeat (500) @(posedge pclk);
        apb(1'b0, 8'h14, 32'h0);
        t0 = rd;
        ex = (gap + 509) / 100;
        check(32'(t0 + 1 >= ex && t0 <= ex + 1), 32'h1);
        // Value frozen by the stopping read, which may tick once more
        apb(1'b0, 8'h14, 32'h0);
        t0 = rd;
        // host adds this reading to marker time and delays
        master.clock_sync(50);
        repeat (300) @(posedge pclk);
        apb(1'b0, 8'h14, 32'h0);
        check(rd, t0);
        apb(1'b1, 8'h04, 32'h2);
        settle;
        check(32'(irq), 32'h0);
        master.clock_sync(100);
        settle;
        check(32'(irq), 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        check(32'(rd <= 32'h2), 32'h1);
        $display("Done: clock sync");
        // interval locked while the receiver runs
        apb(1'b1, 8'h10, 32'h2);
        master.send(5'h01);
        apb(1'b1, 8'h18, 32'h55);
        apb(1'b0, 8'h18, 32'h0);
        check(rd, 32'h64);
        apb(1'b1, 8'h10, 32'h0);
        master.send(5'h01);
        apb(1'b1, 8'h18, 32'h55);
        apb(1'b0, 8'h18, 32'h0);
        check(rd, 32'h55);
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b1, 8'h18, 32'h33);
        apb(1'b0, 8'h18, 32'h0);
        check(rd, 32'h33);
        $display("Done: receiver control");
        close_out;
    end
endmodule
`default_nettype wire
